// file: bench/sfci_core_tb.sv
// sfci_core_tb.sv: self-checking bench of the flash command interface.
// assumes a combinational array model answering at the current address.
`timescale 1ns/100ps
module sfci_core_tb;
   import sfci_pkg::*;
   localparam logic [7:0] ID_M = 8'hC3; // arbitrary value
   localparam logic [7:0] ID_T = 8'h81; // arbitrary value
   localparam logic [7:0] ID_D = 8'h2E; // arbitrary value
   logic              sys_clk, reset_n, sclk, cs_n, h0, h0_oe;
   logic              d0, d0_oe, d1, d1_oe, l0, l1, wel, pd, m3;
   logic              hold_n, wp_n;
   logic [ADDR_W-1:0] maddr, small_addr;
   logic [7:0]        stat, rx, mrd;
   sfci_op_t          op;
   int                errors, check_count, n_small;
   // wire levels; a released line 1 shows the inverse of its last drive
   assign l0 = d0_oe ? d0 : h0;
   assign l1 = d1_oe ? d1 : ~d1;
   assign mrd = maddr[7:0] ^ maddr[15:8] ^ {4'h0, maddr[19:16]};
   sfci_host h (.sys_clk_in(sys_clk), .line0_in(l0), .line1_in(l1),
      .sclk_out(sclk), .cs_n_out(cs_n), .line0_out(h0),
      .line0_oe_out(h0_oe));
   sfci_core #(.MFR_ID(ID_M), .TYPE_ID(ID_T), .DEV_ID(ID_D)) dut (
      .sys_clk_in(sys_clk), .reset_n_in(reset_n), .sclk_in(sclk),
      .cs_n_in(cs_n), .hold_n_in(hold_n), .wp_n_in(wp_n),
      .serial_in_io_line0_in(l0), .serial_in_io_line0_out(d0),
      .serial_in_io_line0_oe_out(d0_oe), .serial_out_io_line1_in(l1),
      .serial_out_io_line1_out(d1), .serial_out_io_line1_oe_out(d1_oe),
      .array_busy_in(1'b0), .mem_rdata_in(mrd), .mem_addr_out(maddr),
      .op_out(op), .status_reg_out(stat), .write_enabled_out(wel),
      .power_down_out(pd), .spi_mode3_out(m3));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // count small-erase pulses; each is a single cycle wide
   always @(posedge sys_clk) if (op.erase_small === 1'b1) begin
      n_small++;
      small_addr = op.addr;
   end
   function automatic logic [7:0] exp_rd(input logic [19:0] a);
      return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
   endfunction : exp_rd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // opcode plus na address bytes, high byte first; stays selected
   task automatic cmd(input logic [7:0] o, input int na,
                      input logic [23:0] a);
      h.sel();
      h.xfer(o, 0, rx);
      for (int i = 2; i > 2 - na; i--) h.xfer(a[8*i+:8], 0, rx);
   endtask : cmd
   task automatic rd(input logic [7:0] o, input logic [23:0] a,
                     input int dum, input bit dual);
      cmd(o, 3, a);
      repeat (dum) h.xfer(8'h00, 0, rx);
      for (int j = 0; j < 3; j++) begin
         h.xfer(8'h00, dual, rx);
         chk(rx, exp_rd(a[19:0] + 20'(j)));
      end
      h.desel();
      chk(d1_oe, 1'b0);
   endtask : rd
   task automatic finish_test();
      if (errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   initial begin
      #300us;
      errors++;
      finish_test();
   end
   initial begin
      logic [23:0] a;
      reset_n = 1'b0;
      hold_n  = 1'b1;
      wp_n    = 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) reset_n = 1'b1;
      void'($urandom(32'h8B8DBCD1));
      rd(OP_READ, $urandom, 0, 0);
      rd(OP_READ, 24'hAFFFFE, 0, 0);
      rd(OP_FREAD, $urandom, 1, 0);
      rd(OP_DOREAD, $urandom, 1, 1);
      chk(m3, 1'b0);
      // small erase under both opcodes, each after a write enable
      for (int k = 0; k < 2; k++) begin
         a = $urandom;
         cmd(OP_WR_EN, 0, a);
         h.desel();
         chk(wel, 1'b1);
         cmd(OP_RD_STAT, 0, a);
         // a held byte clocks nothing and floats the output
         hold_n = 1'b0;
         h.xfer(8'h00, 0, rx);
         chk(d1_oe, 1'b0);
         hold_n = 1'b1;
         h.xfer(8'h00, 0, rx);
         h.desel();
         chk(rx[STAT_WEL_BIT], 1'b1);
         cmd(k ? OP_SSE_B : OP_SSE_A, 3, a);
         h.desel();
         chk(n_small, k + 1);
         chk(small_addr, a[19:0]);
         chk(wel, 1'b0);
      end
      cmd(OP_SSE_A, 3, a);
      h.desel();
      chk(n_small, 2);
      cmd(OP_WR_EN, 0, a);
      h.desel();
      cmd(OP_SSE_A, 2, a);
      h.desel();
      chk(n_small, 2);
      cmd(OP_WR_DIS, 0, a);
      h.desel();
      chk(wel, 1'b0);
      cmd(8'hFF, 1, OP_WR_EN);
      h.desel();
      chk(wel, 1'b0);
      cmd(OP_PWR_DN, 0, a);
      h.desel();
      chk(pd, 1'b1);
      cmd(OP_WR_EN, 0, a);
      h.desel();
      chk(wel, 1'b0);
      cmd(OP_ID_WAKE, 0, a);
      h.desel();
      chk(pd, 1'b0);
      cmd(OP_STD_ID, 0, a);
      for (int i = 0; i < 4; i++) begin
         h.xfer(8'h00, 0, rx);
         chk(rx, (i == 1) ? ID_T : (i == 2) ? ID_D : ID_M);
      end
      h.desel();
      // status write lands, then the lock refuses it with protect low
      cmd(OP_WR_EN, 0, a);
      h.desel();
      cmd(OP_WR_STAT, 0, a);
      h.xfer(8'h80, 0, rx);
      h.desel();
      chk(stat[STAT_LOCK_BIT], 1'b1);
      wp_n = 1'b0;
      cmd(OP_WR_EN, 0, a);
      h.desel();
      cmd(OP_WR_STAT, 0, a);
      h.xfer(8'h00, 0, rx);
      h.desel();
      chk(stat[STAT_LOCK_BIT], 1'b1);
      wp_n = 1'b1;
      h.sclk_out = 1'b1;
      h.sel();
      chk(m3, 1'b1);
      h.desel();
      h.sclk_out = 1'b0;
      finish_test();
   end
endmodule : sfci_core_tb

// file: bench/sfci_host.sv
// sfci_host.sv: behavioural host serial controller for the flash bench.
// assumes the bench resolves line 0 from the device's enable alone.
`timescale 1ns/100ps
module sfci_host (
   input  wire logic sys_clk_in,
   input  wire logic line0_in,
   input  wire logic line1_in,
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      line0_out,
   output logic      line0_oe_out
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      line0_out = 1'b0;
      line0_oe_out = 1'b1;
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask : wait_n
   // select falls while the clock rests, so its level picks the mode
   task automatic sel();
      wait_n(4);
      cs_n_out = 1'b0;
      wait_n(4);
   endtask : sel
   // a released line toggles so a stale value never passes as data
   task automatic desel();
      wait_n(20);
      cs_n_out = 1'b1;
      line0_oe_out = 1'b1;
      line0_out = ~line0_out;
      wait_n(20);
   endtask : desel
   // one byte msb first; dual gives up line 0 and takes bit pairs
   task automatic xfer(input logic [7:0] tx, input bit dual,
                       output logic [7:0] rx);
      for (int i = 0; i < (dual ? 4 : 8); i++) begin
         if (dual) begin
            line0_oe_out = 1'b0;
            line0_out = ~line0_out;
         end else
            line0_out = tx[7-i];
         wait_n(20);
         sclk_out = 1'b1;
         rx = dual ? {rx[5:0], line0_in, line1_in} : {rx[6:0], line1_in};
         wait_n(20);
         sclk_out = 1'b0;
      end
   endtask : xfer
endmodule : sfci_host

// file: rtl/sfci_core.sv
// sfci_core.sv: slave command interface of a serial flash, sampling
// the host serial clock with the system clock.
// assumes the host clock half period spans at least 6 system clocks
// and that the array answers mem_rdata_in within 2 clocks.
// Function
// - capture input bits on serial clock rising edges
// - launch output bits on serial clock falling edges
// - line0 drives data in two-line reads
// - line1 output in dual read, bidirectional dual io
// - select high keeps device idle, inputs ignored
// - select falling edge starts a new transaction
// - input grouped into bytes, most significant first
// - clock level at select fall picks mode
// - protect pin low enforces status lock bit
// - hold low freezes transfer, resumes when high
// - opcode 03h: address, data from fifth byte
// - opcode 0Bh: address, dummy, data from sixth
// - opcode 3Bh: dummy float, two-bit data out
// - opcode BBh: two-bit address, dummy, data
// - D8h with address: 64 KB sector erase
// - lone 60h or C7h erases whole array
// - opcode 02h: address then program data bytes
// - 06h sets, 04h clears write enable latch
// - 05h reads status, 01h writes status
// - B9h sleeps, ABh wakes, identification reads
// - top address bits and dummy values ignored
// - dual io floats lines in last dummies
// - odd data bits out on line0, odd BBh address bits in on line1
// - read address increments and wraps to zero
// - output floats and read ends when deselected
`timescale 1ns/100ps
module sfci_core
   import sfci_pkg::*;
#(
   parameter logic [7:0] MFR_ID   = 8'h5A, // arbitrary value
   parameter logic [7:0] TYPE_ID  = 8'h3C, // arbitrary value
   parameter logic [7:0] DEV_ID   = 8'h14  // arbitrary value
) (
   input  wire logic              sys_clk_in,
   input  wire logic              reset_n_in,
   input  wire logic              sclk_in,
   input  wire logic              cs_n_in,
   input  wire logic              hold_n_in,
   input  wire logic              wp_n_in,
   input  wire logic              serial_in_io_line0_in,
   output logic                   serial_in_io_line0_out,
   output logic                   serial_in_io_line0_oe_out,
   input  wire logic              serial_out_io_line1_in,
   output logic                   serial_out_io_line1_out,
   output logic                   serial_out_io_line1_oe_out,
   input  wire logic              array_busy_in,
   input  wire logic [7:0]        mem_rdata_in,
   output logic      [ADDR_W-1:0] mem_addr_out,
   output sfci_op_t               op_out,
   output logic      [7:0]        status_reg_out,
   output logic                   write_enabled_out,
   output logic                   power_down_out,
   output logic                   spi_mode3_out
);

   sfci_state_t s_q;
   sfci_state_t s_d;
   logic [5:0]  pins_s;
   logic        sclk_s;
   logic        cs_s;
   logic        hold_s;
   logic        wp_s;
   logic        io1_s;
   logic        io0_s;
   logic        rise;
   logic        fall;
   logic        dual_in;
   logic [7:0]  din;
   logic [7:0]  nb;
   logic [7:0]  stat_byte;
   logic        locked;

   // every pin passes two flops before any logic looks at it
   sfci_sync #(
      .W       (6),
      .RST_VAL (PIN_RST)
   ) u_sync (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .d_in       ({sclk_in, cs_n_in, hold_n_in, wp_n_in,
                    serial_out_io_line1_in, serial_in_io_line0_in}),
      .q_out      (pins_s)
   );

   assign {sclk_s, cs_s, hold_s, wp_s, io1_s, io0_s} = pins_s;

   // serial clock edges, seen only while selected and not on hold
   assign rise = sclk_s & ~s_q.sclk_p & ~cs_s & ~s_q.cs_p & hold_s;
   assign fall = ~sclk_s & s_q.sclk_p & ~cs_s & ~s_q.cs_p & hold_s;

   // two-bit input only for the address and dummies of BBh
   assign dual_in = (s_q.cmd == OP_DIOREAD) &
                    (s_q.ph == PH_ADDR || s_q.ph == PH_DUMMY);
   assign din = dual_in ? {s_q.sh[5:0], io1_s, io0_s}
                        : {s_q.sh[6:0], io0_s};

   // live busy and latch bits overlay the stored protect bits
   always_comb begin
      stat_byte                = s_q.stat;
      stat_byte[STAT_BUSY_BIT] = array_busy_in;
      stat_byte[STAT_WEL_BIT]  = s_q.wel;
   end

   // lock only bites while the protect pin is low
   assign locked = ~wp_s & s_q.stat[STAT_LOCK_BIT];

   // next state: one process for the whole transaction engine
   always_comb begin
      s_d                   = s_q;
      nb                    = 8'h00;
      s_d.sclk_p            = sclk_s;
      s_d.cs_p              = cs_s;
      s_d.op.erase_small    = 1'b0;
      s_d.op.erase_sector   = 1'b0;
      s_d.op.erase_chip     = 1'b0;
      s_d.op.prog_valid     = 1'b0;
      s_d.op.status_wr      = 1'b0;
      if (cs_s) begin
         // deselected: idle, outputs float, reads end
         s_d.ph   = PH_IDLE;
         s_d.lz   = 1'b0;
         s_d.done = 1'b0;
         // only complete commands act on the rising select
         if (!s_q.cs_p && s_q.done) begin
            unique case (s_q.cmd)
               OP_WR_EN:  s_d.wel = 1'b1;
               OP_WR_DIS: s_d.wel = 1'b0;
               OP_PWR_DN: s_d.pd  = 1'b1;
               OP_CE_A, OP_CE_B: begin
                  s_d.op.erase_chip = s_q.wel;
                  s_d.wel           = 1'b0;
               end
               OP_SSE_A, OP_SSE_B: begin
                  s_d.op.erase_small = s_q.wel;
                  s_d.op.addr        = s_q.addr;
                  s_d.wel            = 1'b0;
               end
               OP_SE: begin
                  s_d.op.erase_sector = s_q.wel;
                  s_d.op.addr         = s_q.addr;
                  s_d.wel             = 1'b0;
               end
               OP_PROG: s_d.wel = 1'b0;
               OP_WR_STAT: begin
                  // refused quietly while locked
                  if (s_q.wel && !locked) begin
                     s_d.stat         = s_q.op.status_data;
                     s_d.op.status_wr = 1'b1;
                  end
                  s_d.wel = 1'b0;
               end
               default: ;
            endcase
         end
      end else if (s_q.cs_p) begin
         // select fell: fresh transaction, clock level picks mode
         s_d.ph    = PH_CMD;
         s_d.cnt   = 6'h00;
         s_d.mode3 = sclk_s;
         s_d.dual  = 1'b0;
         s_d.ocnt  = 3'h0;
         s_d.idx   = 2'h0;
      end else if (rise) begin
         // capture on rising edges, hold low masks them
         s_d.sh  = din;
         s_d.cnt = s_q.cnt + 6'h01;
         unique case (s_q.ph)
            PH_CMD: begin
               if (s_q.cnt == BYTE_LAST) begin
                  s_d.cmd = din;
                  s_d.cnt = 6'h00;
                  // asleep, only the wake opcode is heard
                  if (s_q.pd && din != OP_ID_WAKE) begin
                     s_d.ph = PH_SKIP;
                  end else begin
                     unique case (din)
                        OP_READ, OP_FREAD, OP_DOREAD, OP_DIOREAD,
                        OP_SSE_A, OP_SSE_B, OP_SE, OP_PROG:
                           s_d.ph = PH_ADDR;
                        OP_ID_WAKE: begin
                           s_d.pd = 1'b0;
                           s_d.ph = PH_ADDR;
                        end
                        OP_STD_ID, OP_RD_STAT: s_d.ph = PH_DOUT;
                        OP_WR_STAT: s_d.ph = PH_DIN;
                        OP_WR_EN, OP_WR_DIS, OP_CE_A, OP_CE_B,
                        OP_PWR_DN: begin
                           s_d.ph   = PH_SKIP;
                           s_d.done = 1'b1;
                        end
                        default: s_d.ph = PH_SKIP;
                     endcase
                  end
               end
            end
            PH_ADDR: begin
               // only the low address bits are kept
               s_d.addr = dual_in ? {s_q.addr[ADDR_W-3:0], io1_s, io0_s}
                                  : {s_q.addr[ADDR_W-2:0], io0_s};
               if (s_q.cnt == (dual_in ? ADDR2_LAST : ADDR1_LAST)) begin
                  s_d.cnt = 6'h00;
                  unique case (s_q.cmd)
                     OP_READ, OP_ID_WAKE: s_d.ph = PH_DOUT;
                     OP_FREAD, OP_DOREAD, OP_DIOREAD:
                        s_d.ph = PH_DUMMY;
                     OP_PROG: begin
                        s_d.ph   = PH_DIN;
                        s_d.done = 1'b1;
                     end
                     default: begin
                        s_d.ph   = PH_SKIP;
                        s_d.done = 1'b1;
                     end
                  endcase
               end
            end
            PH_DUMMY: begin
               // dummy values are ignored and lines stay undriven
               if (s_q.cnt == (dual_in ? DUMMY4_LAST : DUMMY8_LAST))
               begin
                  s_d.ph   = PH_DOUT;
                  s_d.dual = (s_q.cmd != OP_FREAD);
               end
            end
            PH_DIN: begin
               if (s_q.cnt == BYTE_LAST) begin
                  s_d.cnt = 6'h00;
                  if (s_q.cmd == OP_WR_STAT) begin
                     s_d.op.status_data = din;
                     s_d.done           = 1'b1;
                     s_d.ph             = PH_SKIP;
                  end else begin
                     // each byte goes out at once; address wraps
                     // inside its page
                     s_d.op.prog_valid        = s_q.wel;
                     s_d.op.addr              = s_q.addr;
                     s_d.op.program_data_byte = din;
                     s_d.addr[7:0] = s_q.addr[7:0] + 8'h01;
                  end
               end
            end
            PH_IDLE, PH_DOUT, PH_SKIP: ;
         endcase
      end else if (fall && s_q.ph == PH_DOUT) begin
         // launch on falling edges; line drivers turn on here
         s_d.lz = 1'b1;
         if (s_q.ocnt == 3'h0) begin
            unique case (s_q.cmd)
               OP_RD_STAT: nb = stat_byte;
               OP_STD_ID: begin
                  unique case (s_q.idx)
                     2'h0:    nb = MFR_ID;
                     2'h1:    nb = TYPE_ID;
                     default: nb = DEV_ID;
                  endcase
                  s_d.idx = (s_q.idx == ID_LAST) ? 2'h0
                                                 : s_q.idx + 2'h1;
               end
               OP_ID_WAKE: nb = DEV_ID;
               default: begin
                  nb       = mem_rdata_in;
                  s_d.addr = s_q.addr + 20'h00001;
               end
            endcase
            if (s_q.dual) begin
               s_d.d0   = nb[7];
               s_d.d1   = nb[6];
               s_d.osh  = {nb[5:0], 2'b00};
               s_d.ocnt = OUT2_LEFT;
            end else begin
               s_d.d1   = nb[7];
               s_d.osh  = {nb[6:0], 1'b0};
               s_d.ocnt = OUT1_LEFT;
            end
         end else begin
            if (s_q.dual) begin
               s_d.d0  = s_q.osh[7];
               s_d.d1  = s_q.osh[6];
               s_d.osh = {s_q.osh[5:0], 2'b00};
            end else begin
               s_d.d1  = s_q.osh[7];
               s_d.osh = {s_q.osh[6:0], 1'b0};
            end
            s_d.ocnt = s_q.ocnt - 3'h1;
         end
      end
   end

   // whole state registered at once
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // drivers float on deselect or hold without waiting a clock edge
   // line0 drives only in two-line reads
   assign serial_out_io_line1_oe_out = s_q.lz & ~cs_s & hold_s;
   assign serial_in_io_line0_oe_out  = s_q.lz & ~cs_s & hold_s
                                       & s_q.dual;
   assign serial_out_io_line1_out    = s_q.d1;
   assign serial_in_io_line0_out     = s_q.d0;
   assign mem_addr_out      = s_q.addr;
   assign op_out            = s_q.op;
   assign status_reg_out    = stat_byte;
   assign write_enabled_out = s_q.wel;
   assign power_down_out    = s_q.pd;
   assign spi_mode3_out     = s_q.mode3;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!reset_n_in);

   capture_rise_a: assert property (
      $changed(s_q.sh) |-> $past(rise))
      else $error("input shifted without a rising edge");
   launch_fall_a: assert property (
      $changed(s_q.d1) || $changed(s_q.d0) |-> $past(fall))
      else $error("output changed without a falling edge");
   line0_dual_a: assert property (
      serial_in_io_line0_oe_out |->
         s_q.cmd == OP_DOREAD || s_q.cmd == OP_DIOREAD)
      else $error("line0 driven outside a two-line read");
   mode_pick_a: assert property (
      $fell(cs_s) |=> s_q.mode3 == $past(sclk_s))
      else $error("mode not taken from clock level");
   status_lock_a: assert property (
      s_q.op.status_wr |-> $past(!locked && s_q.wel))
      else $error("status written while locked");
   hold_still_a: assert property (
      !hold_s && !cs_s && !s_q.cs_p |=>
         $stable(s_q.cnt) && $stable(s_q.osh) && $stable(s_q.ph))
      else $error("transfer moved during hold");
   wel_set_a: assert property (
      cs_s && !s_q.cs_p && s_q.done && s_q.cmd == OP_WR_EN |=>
         s_q.wel [*2])
      else $error("write enable latch not set");
   pd_skip_a: assert property (
      s_q.pd && s_q.ph == PH_CMD && rise && s_q.cnt == BYTE_LAST
         && din != OP_ID_WAKE |=> s_q.ph == PH_SKIP && s_q.pd)
      else $error("command heard while powered down");
   addr_wrap_a: assert property (
      fall && s_q.ph == PH_DOUT && s_q.ocnt == 3'h0
         && s_q.cmd == OP_READ && s_q.addr == 20'hFFFFF
         |=> s_q.addr == 20'h00000)
      else $error("read address did not wrap");
   desel_end_a: assert property (
      $rose(cs_s) |=> s_q.ph == PH_IDLE && !s_q.lz
         && !serial_out_io_line1_oe_out)
      else $error("read not ended on deselect");
   abandon_a: assert property (
      s_q.op.erase_small || s_q.op.erase_sector || s_q.op.erase_chip
         |-> $past(cs_s && !s_q.cs_p && s_q.done))
      else $error("erase issued without a complete command");

   cov_dual_io_c: cover property (
      s_q.cmd == OP_DIOREAD && serial_in_io_line0_oe_out);
   cov_prog_c: cover property (s_q.op.prog_valid);
   cov_chip_c: cover property (s_q.op.erase_chip);
   cov_wrap_c: cover property (
      s_q.cmd == OP_READ && $past(s_q.addr) == 20'hFFFFF
         && s_q.addr == 20'h00000);

endmodule : sfci_core

// file: rtl/sfci_pkg.sv
// sfci_pkg.sv: opcodes, field positions, phase counts and carrier
// types of the serial flash command interface.
// assumes a 20-bit byte address held inside a 24-bit serial address.
package sfci_pkg;

   // address bits kept by the device; upper serial bits fall away
   localparam int ADDR_W = 20;

   // command opcodes
   localparam logic [7:0] OP_READ    = 8'h03;
   localparam logic [7:0] OP_FREAD   = 8'h0B;
   localparam logic [7:0] OP_DOREAD  = 8'h3B;
   localparam logic [7:0] OP_DIOREAD = 8'hBB;
   localparam logic [7:0] OP_SSE_A   = 8'h20;
   localparam logic [7:0] OP_SSE_B   = 8'hD7;
   localparam logic [7:0] OP_SE      = 8'hD8;
   localparam logic [7:0] OP_CE_A    = 8'h60;
   localparam logic [7:0] OP_CE_B    = 8'hC7;
   localparam logic [7:0] OP_PROG    = 8'h02;
   localparam logic [7:0] OP_WR_EN   = 8'h06;
   localparam logic [7:0] OP_WR_DIS  = 8'h04;
   localparam logic [7:0] OP_PWR_DN  = 8'hB9;
   localparam logic [7:0] OP_RD_STAT = 8'h05;
   localparam logic [7:0] OP_WR_STAT = 8'h01;
   localparam logic [7:0] OP_STD_ID  = 8'h9F;
   localparam logic [7:0] OP_ID_WAKE = 8'hAB;

   // status byte field positions and reset value
   localparam int         STAT_BUSY_BIT = 0;
   localparam int         STAT_WEL_BIT  = 1;
   localparam int         STAT_LOCK_BIT = 7;
   localparam logic [7:0] STAT_RST      = 8'h00;

   // last count index of each input phase in rising clock edges, then output bits left after the first launch, and the last id byte index
   localparam logic [5:0] BYTE_LAST   = 6'h07;
   localparam logic [5:0] ADDR1_LAST  = 6'h17; // 24 clocks, one line
   localparam logic [5:0] ADDR2_LAST  = 6'h0B; // 12 clocks, two lines
   localparam logic [5:0] DUMMY8_LAST = 6'h07;
   localparam logic [5:0] DUMMY4_LAST = 6'h03;
   localparam logic [2:0] OUT1_LEFT   = 3'h7; // launches after the first
   localparam logic [2:0] OUT2_LEFT   = 3'h3;
   localparam logic [1:0] ID_LAST     = 2'h2;

   // synchroniser reset: {clk, select, hold, protect, line1, line0}
   localparam logic [5:0] PIN_RST = 6'h1C;

   typedef enum logic [6:0] {
      PH_IDLE  = 7'h01,
      PH_CMD   = 7'h02,
      PH_ADDR  = 7'h04,
      PH_DUMMY = 7'h08,
      PH_DIN   = 7'h10,
      PH_DOUT  = 7'h20,
      PH_SKIP  = 7'h40
   } sfci_phase_t;

   // requests handed to the array side; flags are one-cycle pulses
   typedef struct packed {
      logic              erase_small;
      logic              erase_sector;
      logic              erase_chip;
      logic              prog_valid;
      logic              status_wr;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        program_data_byte;
      logic [7:0]        status_data;
   } sfci_op_t;

   typedef struct packed {
      sfci_phase_t       ph;
      logic [7:0]        cmd;
      logic [7:0]        sh;
      logic [5:0]        cnt;
      logic [ADDR_W-1:0] addr;
      logic              done;
      logic              dual;
      logic              lz;
      logic [7:0]        osh;
      logic [2:0]        ocnt;
      logic [1:0]        idx;
      logic              mode3;
      logic              wel;
      logic              pd;
      logic [7:0]        stat;
      logic              sclk_p;
      logic              cs_p;
      logic              d0;
      logic              d1;
      sfci_op_t          op;
   } sfci_state_t;

   localparam sfci_state_t ST_RST = '{ph: PH_IDLE, cs_p: 1'b1,
                                      stat: STAT_RST, default: '0};

endpackage : sfci_pkg

// file: rtl/sfci_sync.sv
// sfci_sync.sv: two-stage synchroniser for pins from outside the
// system clock; assumes each bit is an independent level.
`timescale 1ns/100ps
module sfci_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         sys_clk_in,
   input  wire logic         reset_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_q <= RST_VAL;
         q_out  <= RST_VAL;
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end

endmodule : sfci_sync
